// ### logic/trap_pkg.sv
package trap_pkg;

    // Register byte offsets on the bus
    localparam logic [11:0] OFF_STATUS = 12'h000;
    localparam logic [11:0] OFF_ENABLE = 12'h004;
    localparam logic [11:0] OFF_PENDING = 12'h008;
    localparam logic [11:0] OFF_VECTOR = 12'h00c;
    localparam logic [11:0] OFF_RETURN_PC = 12'h010;
    localparam logic [11:0] OFF_CAUSE = 12'h014;
    localparam logic [11:0] OFF_LAST_FETCH = 12'h018;

    // Field positions in the status register
    localparam int STATUS_GIE_BIT = 3;
    localparam int STATUS_PIE_BIT = 7;

    // Vector register layout: base in bits 31 to 8, mode in bit 0
    localparam int VECTOR_BASE_LSB = 8;
    localparam int VECTOR_MODE_BIT = 0;
    localparam logic VEC_MODE_DIRECT = 1'b0;
    localparam logic VEC_MODE_VECTORED = 1'b1;

    // Interrupt lines that exist: 31..16, 11, 7 and 3
    localparam logic [31:0] IRQ_VALID_MASK = 32'hffff0888;
    localparam int IRQ_EXT_LINE = 11;
    localparam int IRQ_TIMER_LINE = 7;
    localparam int IRQ_SOFT_LINE = 3;
    localparam int IRQ_CUSTOM_LSB = 16;

    // Cause codes and the interrupt flag position
    localparam logic [4:0] CAUSE_ILLEGAL = 5'h02;
    localparam logic [4:0] CAUSE_BREAKPOINT = 5'h03;
    localparam logic [4:0] CAUSE_ECALL_M = 5'h0b;
    localparam int CAUSE_IRQ_BIT = 31;

    // Reset values
    localparam logic [31:0] RESET_ZERO = 32'h00000000;
    localparam logic [31:0] ENABLE_RESET = 32'h00000000;

    // Kinds of fetch redirect, for the last-fetch register
    typedef enum logic [2:0] {
        REDIR_NONE = 3'b000,
        REDIR_BOOT = 3'b001,
        REDIR_EXCEPTION = 3'b010,
        REDIR_INTERRUPT = 3'b011,
        REDIR_RETURN = 3'b100
    } redirect_kind_t;

endpackage

// ### logic/irq_priority_select.sv
`timescale 1ns/10ps

// Fixed-priority pick among requesting lines: highest index wins,
// except that the timer line is served only when nothing else asks.
module irq_priority_select (
    // Requests, already masked by enables
    input wire logic [31:0] request,
    // Selection
    output logic any_request,
    output logic [4:0] index
);

    logic [31:0] others;
    logic [4:0] high_index;

    // Timer line is pulled out so that it ranks below the software line
    assign others = request & ~(32'h00000001 << trap_pkg::IRQ_TIMER_LINE);
    assign any_request = |request;

    // Highest set bit among the non-timer lines
    always_comb begin
        high_index = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (others[i]) begin
                high_index = 5'(i);
            end
        end
    end

    // Timer last
    assign index = (|others) ? high_index : 5'(trap_pkg::IRQ_TIMER_LINE);

endmodule

// ### logic/machine_trap_interrupt_unit.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps

// What this block does
// - On any trap, save the current PC and copy global enable to previous-enable.
// - Every exception redirects fetch to the vector base, whatever the mode.
// - Interrupts go to base in direct mode, base plus four times index if vectored.
// - Machine return jumps to the saved PC and restores global enable from previous.
// - After reset, fetch starts at the boot location input.
// - Lines 11, 7, 3 are external, timer, software; 31 to 16 are custom.
// - A taken interrupt pulses the taken output one cycle with its 5-bit index.
// - Upper sixteen bits of enable and pending serve custom lines 31 to 16.
// - After reset every interrupt is disabled.
// - Take an interrupt only when global enable and its line enable are set.
// - Priority falls with line number, 31 to 16, then 11, 3, timer last.
// - No interrupt is taken while in debug mode.
// - Illegal instruction records cause 2, breakpoint records cause 3.
// - Any access to the absent time counters raises an illegal-instruction trap.
// - Illegal-instruction and environment-call traps cannot be disabled; ecall is 11.
// - Trap entry clears global enable; hardware never nests traps itself.
module machine_trap_interrupt_unit (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core pipeline events
    input wire logic [31:0] boot_addr,
    input wire logic [31:0] current_pc,
    input wire logic illegal_instr,
    input wire logic breakpoint,
    input wire logic ecall,
    input wire logic time_csr_access,
    input wire logic mret,
    input wire logic debug_mode,
    // Fetch redirect
    output logic fetch_redirect,
    output logic [31:0] fetch_addr,
    // Interrupt lines and acknowledge
    input wire logic [31:0] irq,
    output logic irq_taken,
    output logic [4:0] taken_interrupt_index,
    // Status for the core
    output logic global_irq_enable
);

    // Architectural state
    logic gie_q;
    logic gie_d;
    logic pie_q;
    logic pie_d;
    logic [31:0] enable_q;
    logic [31:0] enable_d;
    logic [31:8] vec_base_q;
    logic [31:8] vec_base_d;
    logic vec_mode_q;
    logic vec_mode_d;
    logic [31:0] return_pc_q;
    logic [31:0] return_pc_d;
    logic cause_irq_q;
    logic cause_irq_d;
    logic [4:0] cause_code_q;
    logic [4:0] cause_code_d;

    // Fetch and acknowledge outputs
    logic boot_pending_q;
    logic redirect_q;
    logic redirect_d;
    logic [31:0] fetch_addr_q;
    logic [31:0] fetch_addr_d;
    logic taken_q;
    logic taken_d;
    logic [4:0] taken_index_q;
    logic [4:0] taken_index_d;
    trap_pkg::redirect_kind_t last_kind_q;
    trap_pkg::redirect_kind_t last_kind_d;

    // Bus state
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // Bus decode
    logic [11:0] reg_off;
    logic access;
    logic wr_commit;
    logic sel_status;
    logic sel_enable;
    logic sel_pending;
    logic sel_vector;
    logic sel_return_pc;
    logic sel_cause;
    logic sel_last_fetch;
    logic addr_hit;
    logic [31:0] rd_mux;

    // Trap decision
    logic [31:0] pending;
    logic [31:0] armed;
    logic irq_any;
    logic [4:0] irq_index;
    logic irq_take;
    logic illegal_any;
    logic exc_take;
    logic [4:0] exc_code;
    logic ret_take;
    logic [31:0] vec_base_addr;
    logic [31:0] irq_target;

    // Only existing lines are seen as pending; upper half is custom
    assign pending = irq & trap_pkg::IRQ_VALID_MASK;

    // A line is armed only with global and line enable, never in debug
    assign armed = (gie_q && !debug_mode) ? (pending & enable_q) : 32'h00000000;

    irq_priority_select u_select (
        .request(armed),
        .any_request(irq_any),
        .index(irq_index)
    );

    // Time counters are absent, so touching them is just an illegal instruction
    assign illegal_any = illegal_instr | time_csr_access;

    // Exceptions outrank interrupts, interrupts outrank the return
    assign exc_take = illegal_any | breakpoint | ecall;
    assign irq_take = irq_any && !exc_take;
    assign ret_take = mret && !exc_take && !irq_any;

    // Cause code of the winning exception
    assign exc_code = illegal_any ? trap_pkg::CAUSE_ILLEGAL :
                      breakpoint ? trap_pkg::CAUSE_BREAKPOINT :
                      trap_pkg::CAUSE_ECALL_M;

    // Handler addresses; the low byte of the base is always zero
    // Index times four stays below 128, so the offset never leaves the aligned window
    assign vec_base_addr = {vec_base_q, 8'h00};
    assign irq_target = (vec_mode_q == trap_pkg::VEC_MODE_VECTORED) ?
                        vec_base_addr + {25'h0000000, irq_index, 2'b00} :
                        vec_base_addr;

    // Bus address decode, one aligned word per register
    assign reg_off = paddr[11:0];
    assign access = psel && penable;
    assign sel_status = (reg_off == trap_pkg::OFF_STATUS);
    assign sel_enable = (reg_off == trap_pkg::OFF_ENABLE);
    assign sel_pending = (reg_off == trap_pkg::OFF_PENDING);
    assign sel_vector = (reg_off == trap_pkg::OFF_VECTOR);
    assign sel_return_pc = (reg_off == trap_pkg::OFF_RETURN_PC);
    assign sel_cause = (reg_off == trap_pkg::OFF_CAUSE);
    assign sel_last_fetch = (reg_off == trap_pkg::OFF_LAST_FETCH);
    assign addr_hit = (paddr[31:12] == 20'h00000) && (sel_status || sel_enable ||
                      sel_pending || sel_vector || sel_return_pc || sel_cause ||
                      sel_last_fetch);
    // Writes land only at the edge that completes the access
    assign wr_commit = access && pready_q && pwrite && addr_hit;

    // Read data selection; unmapped words read as zero
    assign rd_mux = !addr_hit ? 32'h00000000 :
        sel_status ? ((32'(gie_q) << trap_pkg::STATUS_GIE_BIT) |
                      (32'(pie_q) << trap_pkg::STATUS_PIE_BIT)) :
        sel_enable ? enable_q :
        sel_pending ? pending :
        sel_vector ? (vec_base_addr | 32'(vec_mode_q)) :
        sel_return_pc ? return_pc_q :
        sel_cause ? {cause_irq_q, 26'h0000000, cause_code_q} :
        sel_last_fetch ? {29'h00000000, last_kind_q} :
        32'h00000000;

    // Bus answer: one wait state, so read data leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= trap_pkg::RESET_ZERO;
            pslverr_q <= 1'b0;
        end else begin
            // Error and data launch with pready so all three stand together
            pready_q <= access && !pready_q;
            prdata_q <= (access && !pready_q && !pwrite) ? rd_mux : 32'h00000000;
            pslverr_q <= access && !pready_q && !addr_hit;
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // Enable state: traps and return win over a bus write in the same cycle
    always_comb begin
        gie_d = gie_q;
        pie_d = pie_q;
        if (wr_commit && sel_status) begin
            gie_d = pwdata[trap_pkg::STATUS_GIE_BIT];
            pie_d = pwdata[trap_pkg::STATUS_PIE_BIT];
        end
        // Hardware update comes last so it overrides a same-cycle write
        if (exc_take || irq_take) begin
            pie_d = gie_q;
            gie_d = 1'b0;
        end else if (ret_take) begin
            gie_d = pie_q;
            pie_d = 1'b1;
        end
    end

    // Software-owned registers; only existing lines can be enabled
    always_comb begin
        enable_d = enable_q;
        vec_base_d = vec_base_q;
        vec_mode_d = vec_mode_q;
        if (wr_commit && sel_enable) begin
            enable_d = pwdata & trap_pkg::IRQ_VALID_MASK;
        end
        if (wr_commit && sel_vector) begin
            vec_base_d = pwdata[31:trap_pkg::VECTOR_BASE_LSB];
            vec_mode_d = pwdata[trap_pkg::VECTOR_MODE_BIT];
        end
    end

    // Saved PC and cause
    always_comb begin
        return_pc_d = return_pc_q;
        cause_irq_d = cause_irq_q;
        cause_code_d = cause_code_q;
        if (wr_commit && sel_return_pc) begin
            return_pc_d = {pwdata[31:1], 1'b0};
        end
        if (wr_commit && sel_cause) begin
            cause_irq_d = pwdata[trap_pkg::CAUSE_IRQ_BIT];
            cause_code_d = pwdata[4:0];
        end
        // Trap entry overrides a software write in the same cycle
        if (exc_take) begin
            return_pc_d = current_pc;
            cause_irq_d = 1'b0;
            cause_code_d = exc_code;
        end else if (irq_take) begin
            return_pc_d = current_pc;
            cause_irq_d = 1'b1;
            cause_code_d = irq_index;
        end
    end

    // Fetch redirect choice; boot comes first after reset
    always_comb begin
        redirect_d = 1'b0;
        fetch_addr_d = fetch_addr_q;
        last_kind_d = last_kind_q;
        taken_index_d = taken_index_q;
        if (boot_pending_q) begin
            redirect_d = 1'b1;
            fetch_addr_d = boot_addr;
            last_kind_d = trap_pkg::REDIR_BOOT;
        end else if (exc_take) begin
            redirect_d = 1'b1;
            fetch_addr_d = vec_base_addr;
            last_kind_d = trap_pkg::REDIR_EXCEPTION;
        end else if (irq_take) begin
            redirect_d = 1'b1;
            fetch_addr_d = irq_target;
            last_kind_d = trap_pkg::REDIR_INTERRUPT;
            taken_index_d = irq_index;
        end else if (ret_take) begin
            redirect_d = 1'b1;
            fetch_addr_d = return_pc_q;
            last_kind_d = trap_pkg::REDIR_RETURN;
        end
    end

    // State flops; enables come up cleared so nothing is taken after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_q <= 1'b0;
            pie_q <= 1'b0;
            enable_q <= trap_pkg::ENABLE_RESET;
            vec_base_q <= 24'h000000;
            vec_mode_q <= trap_pkg::VEC_MODE_DIRECT;
            return_pc_q <= trap_pkg::RESET_ZERO;
            cause_irq_q <= 1'b0;
            cause_code_q <= 5'h00;
        end else begin
            gie_q <= gie_d;
            pie_q <= pie_d;
            enable_q <= enable_d;
            vec_base_q <= vec_base_d;
            vec_mode_q <= vec_mode_d;
            return_pc_q <= return_pc_d;
            cause_irq_q <= cause_irq_d;
            cause_code_q <= cause_code_d;
        end
    end

    // Acknowledge goes out with the redirect; the boot cycle never acknowledges
    assign taken_d = irq_take && !boot_pending_q;

    // Boot address is caught by the clock after release, never by the reset itself
    // Exceptions in the boot cycle still update state, so the core must not raise them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_pending_q <= 1'b1;
        end else begin
            boot_pending_q <= 1'b0;
        end
    end

    // Fetch outputs and the one-cycle acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            redirect_q <= 1'b0;
            fetch_addr_q <= trap_pkg::RESET_ZERO;
            last_kind_q <= trap_pkg::REDIR_NONE;
            taken_q <= 1'b0;
            taken_index_q <= 5'h00;
        end else begin
            redirect_q <= redirect_d;
            fetch_addr_q <= fetch_addr_d;
            last_kind_q <= last_kind_d;
            taken_q <= taken_d;
            taken_index_q <= taken_index_d;
        end
    end

    // Index holds its last value between pulses; only valid with the pulse
    assign fetch_redirect = redirect_q;
    assign fetch_addr = fetch_addr_q;
    assign irq_taken = taken_q;
    assign taken_interrupt_index = taken_index_q;
    assign global_irq_enable = gie_q;

endmodule

// ### test/irq_source_model.sv
`timescale 1ns/10ps

// Level source: a raised line stays up until the taken pulse names it
module irq_source_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requests and acknowledge
    input wire logic [31:0] raise,
    input wire logic irq_taken,
    input wire logic [4:0] taken_interrupt_index,
    // Lines to the unit
    output logic [31:0] irq
);
    logic [31:0] lvl_q;
    logic [31:0] lvl_d;
    logic [31:0] ack;

    // Index is only trusted during the pulse, since it holds otherwise
    assign ack = irq_taken ? (32'h00000001 << taken_interrupt_index) : 32'h00000000;
    assign lvl_d = (lvl_q & ~ack) | raise;
    // Reserved lines stay low whatever is asked
    assign irq = lvl_q & trap_pkg::IRQ_VALID_MASK;

    // Level store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= 32'h00000000;
        end else begin
            lvl_q <= lvl_d;
        end
    end
endmodule

// ### test/trap_unit_chk.sv
`timescale 1ns/10ps

// Port-level checks; one clock, so defaults carry clock and reset
module trap_unit_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Core side
    input wire logic [31:0] boot_addr,
    input wire logic illegal_instr,
    input wire logic time_csr_access,
    input wire logic debug_mode,
    input wire logic fetch_redirect,
    input wire logic [31:0] fetch_addr,
    // Interrupts
    input wire logic [31:0] irq,
    input wire logic irq_taken,
    input wire logic [4:0] taken_interrupt_index,
    input wire logic global_irq_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_boot_fetch: assert property (
        $rose(presetn) |=> fetch_redirect && fetch_addr == $past(boot_addr))
        else $error("boot fetch wrong");
    a_taken_pulse: assert property (irq_taken |=> !irq_taken)
        else $error("taken pulse too long");
    a_taken_enabled: assert property (irq_taken |-> $past(global_irq_enable))
        else $error("taken while disabled");
    a_debug_quiet: assert property (irq_taken |-> !$past(debug_mode))
        else $error("taken in debug");
    a_taken_line: assert property (
        irq_taken |-> |($past(irq) & (32'h00000001 << taken_interrupt_index)))
        else $error("taken line not pending");
    a_taken_redirect: assert property (irq_taken |-> fetch_redirect)
        else $error("no redirect on take");
    a_entry_gie_off: assert property (irq_taken |-> !global_irq_enable)
        else $error("enable kept on entry");
    a_illegal_traps: assert property (
        (illegal_instr || time_csr_access) |=> fetch_redirect)
        else $error("illegal not trapped");
endmodule

bind machine_trap_interrupt_unit trap_unit_chk i_chk (.pclk(pclk), .presetn(presetn),
    .boot_addr(boot_addr), .illegal_instr(illegal_instr),
    .time_csr_access(time_csr_access), .debug_mode(debug_mode),
    .fetch_redirect(fetch_redirect), .fetch_addr(fetch_addr), .irq(irq),
    .irq_taken(irq_taken), .taken_interrupt_index(taken_interrupt_index),
    .global_irq_enable(global_irq_enable));

// ### test/machine_trap_interrupt_unit_bench.sv
`timescale 1ns/10ps

// Bus and event driver; a level source model sits on the lines
module machine_trap_interrupt_unit_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] current_pc = 32'h00000200;
    logic [31:0] boot_loc = 32'h00008000;
    logic [4:0] ev = 5'h00;
    logic debug_mode = 1'b0;
    logic fetch_redirect;
    logic [31:0] fetch_addr;
    logic [31:0] irq;
    logic [31:0] raise = 32'h00000000;
    logic irq_taken;
    logic [4:0] taken_interrupt_index;
    logic global_irq_enable;
    logic [31:0] rdat;
    logic rerr;
    logic [31:0] cause_exp [4] = '{32'h00000002, 32'h00000003, 32'h0000000b, 32'h00000002};
    logic [4:0] order [5] = '{5'h1f, 5'h10, 5'h0b, 5'h03, 5'h07};
    int fails = 0;
    int checks_done = 0;

    always #5 pclk = ~pclk;

    // Event bits: illegal, breakpoint, ecall, time access, return
    machine_trap_interrupt_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_addr(boot_loc),
        .current_pc(current_pc), .illegal_instr(ev[0]), .breakpoint(ev[1]),
        .ecall(ev[2]), .time_csr_access(ev[3]), .mret(ev[4]), .debug_mode(debug_mode),
        .fetch_redirect(fetch_redirect), .fetch_addr(fetch_addr), .irq(irq),
        .irq_taken(irq_taken), .taken_interrupt_index(taken_interrupt_index),
        .global_irq_enable(global_irq_enable));

    irq_source_model i_src (.pclk(pclk), .presetn(presetn), .raise(raise),
        .irq_taken(irq_taken), .taken_interrupt_index(taken_interrupt_index), .irq(irq));

    task automatic finish_test;
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            $display("[ERR] %0t %s got %h want %h", $time, m, g, e);
            fails++;
        end
    endtask

    // One idle cycle before each setup keeps psel from being set twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 32'(a);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Values read right after the edge are the ones that edge sampled
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            finish_test();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
        apb(1'b0, a, 32'h00000000);
        chk(rdat, e, "read");
        chk(32'(rerr), 32'(er), "slverr");
    endtask

    // Event pulse; redirect is due exactly one cycle later
    task automatic pulse(input int k, input logic [31:0] a);
        @(posedge pclk);
        ev <= 5'(1 << k);
        @(posedge pclk);
        ev <= 5'h00;
        @(negedge pclk);
        chk(32'(fetch_redirect), 32'h00000001, "redirect");
        chk(fetch_addr, a, "target");
    endtask

    task automatic lines(input logic [31:0] v);
        @(posedge pclk);
        raise <= v;
        @(posedge pclk);
        raise <= 32'h00000000;
    endtask

    task automatic take(input logic [4:0] id, input logic [31:0] a);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (irq_taken !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            finish_test();
        end
        chk(32'(taken_interrupt_index), 32'(id), "index");
        chk(fetch_addr, a, "vector");
        chk(32'(global_irq_enable), 32'h00000000, "entry enable");
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge pclk);
            chk(32'(irq_taken), 32'h00000000, "unexpected take");
        end
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk(32'(fetch_redirect), 32'h00000001, "boot");
        chk(fetch_addr, 32'h00008000, "boot");
        chk(32'(global_irq_enable), 32'h00000000, "reset enable");
        rd(trap_pkg::OFF_ENABLE, 32'h00000000, 1'b0);
        rd(12'h01c, 32'h00000000, 1'b1);
        apb(1'b1, trap_pkg::OFF_VECTOR, 32'h00001000);
        // Every exception kind, each with its own saved PC
        for (int k = 0; k < 4; k++) begin
            current_pc <= 32'h00000200 + 32'(k) * 4;
            pulse(k, 32'h00001000);
            rd(trap_pkg::OFF_CAUSE, cause_exp[k], 1'b0);
            rd(trap_pkg::OFF_RETURN_PC, 32'h00000200 + 32'(k) * 4, 1'b0);
        end
        apb(1'b1, trap_pkg::OFF_VECTOR, 32'h00001001);
        apb(1'b1, trap_pkg::OFF_STATUS, 32'h00000008);
        pulse(0, 32'h00001000);
        rd(trap_pkg::OFF_STATUS, 32'h00000080, 1'b0);
        pulse(4, 32'h0000020c);
        rd(trap_pkg::OFF_STATUS, 32'h00000088, 1'b0);
        rd(trap_pkg::OFF_LAST_FETCH, 32'h00000004, 1'b0);
        // Lines 31, 16, 11, 7 and 3 at once, then served one by one in priority order
        apb(1'b1, trap_pkg::OFF_STATUS, 32'h00000000);
        apb(1'b1, trap_pkg::OFF_ENABLE, 32'hffffffff);
        rd(trap_pkg::OFF_ENABLE, 32'hffff0888, 1'b0);
        lines(32'h80010888);
        rd(trap_pkg::OFF_PENDING, 32'h80010888, 1'b0);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, trap_pkg::OFF_STATUS, 32'h00000008);
            take(order[i], 32'h00001000 + 32'(order[i]) * 4);
        end
        @(posedge pclk);
        debug_mode <= 1'b1;
        lines(32'h00000800);
        apb(1'b1, trap_pkg::OFF_STATUS, 32'h00000008);
        quiet(6);
        apb(1'b1, trap_pkg::OFF_STATUS, 32'h00000000);
        debug_mode <= 1'b0;
        quiet(6);
        apb(1'b1, trap_pkg::OFF_VECTOR, 32'h00001000);
        apb(1'b1, trap_pkg::OFF_STATUS, 32'h00000008);
        take(5'h0b, 32'h00001000);
        // Second reset in mid-run, with a new boot location held in a register
        @(posedge pclk);
        presetn <= 1'b0;
        boot_loc <= 32'h00004000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk(32'(fetch_redirect), 32'h00000001, "reboot");
        chk(fetch_addr, 32'h00004000, "reboot");
        rd(trap_pkg::OFF_ENABLE, 32'h00000000, 1'b0);
        rd(trap_pkg::OFF_STATUS, 32'h00000000, 1'b0);
        finish_test();
    end
endmodule
